// >>> sim/atb_far_model.sv
// Purpose: far-side sources: input channels, trigger pin, other timers
// Assumes: every source idles low between pulses
// Notes:   each level lasts four cycles, well past a zero-length filter
`timescale 1ns/10ps
module atb_far_model (
  input wire ref_clk,
  output reg [3:0] ch_in,
  output reg external_trigger_input,
  output reg [3:0] itr_in
);
  // ==========
  // idle levels from time zero
  initial begin
    ch_in = 4'h0;
    external_trigger_input = 1'b0;
    itr_in = 4'h0;
  end
  // src 0 channel, 1 trigger pin, 2 other timer output (no filter there)
  task automatic pulse(input [1:0] src, input [1:0] idx, input [3:0] n);
    integer k;
    for (k = 0; k < 2 * n; k = k + 1) begin
      @(posedge ref_clk);
      if (src == 2'h0) ch_in[idx] <= ~ch_in[idx];
      else if (src == 2'h1) external_trigger_input <= ~external_trigger_input;
      else itr_in[idx] <= ~itr_in[idx];
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule // atb_far_model

// >>> sim/atb_timer_props.sv
// Purpose: port assertions for the timebase and capture timer
// Assumes: all bus writes use every byte lane
// Notes:   mirrors only the control bits the properties need
`timescale 1ns/10ps
`include "atb_timer_consts.vh"
module atb_timer_props (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire [15:0] counter_value,
  input wire update_evt,
  input wire irq,
  input wire dma_req
);
  // ==========
  // mirror of direction, update disable and enables
  wire wr_hit = avs_write && !avs_waitrequest && clk_en;
  reg [1:0] dir_ff;
  reg ud_ff;
  reg [8:0] ien_ff;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_ff <= 2'h0;
      ud_ff <= 1'b0;
      ien_ff <= 9'h000;
    end else if (wr_hit && avs_address == `ATB_OFS_CTRL1) begin
      dir_ff <= avs_writedata[3:2];
      ud_ff <= avs_writedata[1];
    end else if (wr_hit && avs_address == `ATB_OFS_IEN) begin
      ien_ff <= avs_writedata[8:0];
    end
  end
  // ==========
  // properties; writes may move the counter, so their cycles are skipped
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_up_step: assert property (
    dir_ff == `ATB_DIR_UP && $changed(counter_value) && !$past(wr_hit)
    |-> counter_value == $past(counter_value) + 16'h0001 || counter_value == 16'h0000)
    else $error("up step wrong");
  chk_down_step: assert property (
    dir_ff == `ATB_DIR_DOWN && $changed(counter_value) && !$past(wr_hit)
    |-> counter_value == $past(counter_value) - 16'h0001 || $past(counter_value) == 16'h0000)
    else $error("down step wrong");
  chk_center_step: assert property (
    dir_ff == `ATB_DIR_CENTER && $changed(counter_value) && !$past(wr_hit)
    |-> counter_value == $past(counter_value) + 16'h0001
    || counter_value == $past(counter_value) - 16'h0001) else $error("center step wrong");
  chk_update_at_zero: assert property (
    dir_ff == `ATB_DIR_UP && update_evt && !$past(wr_hit) && !$past(wr_hit, 2)
    |-> counter_value == 16'h0000) else $error("update not at wrap");
  chk_update_blocked: assert property (
    ud_ff && !$past(wr_hit) && !$past(wr_hit, 2) |-> !update_evt)
    else $error("update while disabled");
  chk_irq_cause: assert property (
    irq |-> ien_ff[5:0] != 6'h00) else $error("irq without enable");
  chk_dma_cause: assert property (
    dma_req |-> ien_ff[8]) else $error("dma without enable");
  chk_wait_first: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no first wait");
  chk_wait_once: assert property (
    (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest || !clk_en)
    else $error("wait too long");
  cover property (update_evt && dir_ff == `ATB_DIR_CENTER);
  cover property (irq);
  cover property (dma_req);
endmodule // atb_timer_props
bind atb_timer atb_timer_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .counter_value(counter_value), .update_evt(update_evt), .irq(irq), .dma_req(dma_req));

// >>> sim/tb_atb_timer.sv
// Purpose: self-checking bench for the timebase and capture timer
// Assumes: clock enable and byte lanes held on
// Notes:   short reload and repetition values keep the run small
`timescale 1ns/10ps
`include "atb_timer_consts.vh"
module tb_atb_timer;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [5:0] avs_address = 6'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0000_0000;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [3:0] ch_in;
  wire external_trigger_input;
  wire [3:0] itr_in;
  wire [15:0] counter_value;
  wire update_evt;
  wire irq;
  wire dma_req;
  wire trigger_evt;
  integer mismatches = 0;
  integer tests_run = 0;
  integer i;
  integer hits;
  integer trg = 0;
  reg [31:0] q;
  reg [15:0] cnt_exp;
  reg [31:0] ext_tab [0:4];
  localparam RLD = 3;
  localparam PSV = 1;
  localparam RPV = 2;
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge ref_clk) trg = trg + trigger_evt;
  atb_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ch_in(ch_in), .external_trigger_input(external_trigger_input), .itr_in(itr_in),
    .counter_value(counter_value), .update_evt(update_evt), .trigger_evt(trigger_evt), .irq(irq),
    .dma_req(dma_req));
  atb_far_model far (.ref_clk(ref_clk), .ch_in(ch_in),
    .external_trigger_input(external_trigger_input), .itr_in(itr_in));
  // ==========
  // comparison, bus and timing helpers
  task automatic check(input [31:0] seen, input [31:0] exp, input string nm);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is seen low, then released
  task automatic bus(input rd, input [5:0] a, input [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= d;
    do begin
      @(negedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic wr(input [5:0] a, input [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic rd(input [5:0] a, input [31:0] m, input [31:0] e, input string nm);
    bus(1'b1, a, 32'h0000_0000);
    check(q & m, e, nm);
  endtask
  // the first two pulses may straddle a mode change, so only the third gap counts
  task automatic gap(input [31:0] e);
    integer n;
    repeat (3) begin
      n = 0;
      do begin
        @(negedge ref_clk);
        n = n + 1;
      end while (update_evt !== 1'b1 && n < 900);
    end
    check(n, e, "update gap");
  endtask
  task automatic complete_run;
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========
  // watchdog, far beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    complete_run;
  end
  // ==========
  // main sequence; ext_tab holds mode word, then source, channel and pulse count
  initial begin
    ext_tab[0] = {16'h0001, 16'h0003};
    ext_tab[1] = {16'h0009, 16'h0022};
    ext_tab[2] = {16'h0011, 16'h0002};
    ext_tab[3] = {16'h0002, 16'h0103};
    ext_tab[4] = {16'h2003, 16'h0212};
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`ATB_OFS_RELOAD, 32'hFFFF, 32'hFFFF, "reload reset");
    rd(`ATB_OFS_PSC, 32'hFFFF, 32'h0, "prescaler reset");
    rd(6'h38, 32'hFFFF_FFFF, 32'h0, "unmapped");
    wr(`ATB_OFS_RELOAD, RLD);
    wr(`ATB_OFS_PSC, PSV);
    wr(`ATB_OFS_REP, RPV);
    wr(`ATB_OFS_IEN, 32'h100);
    wr(`ATB_OFS_EVGEN, 32'h1);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`ATB_OFS_CTRL1, 32'h1 | (i << 2));
      gap((RPV + 1) * (RLD + (i < 2 ? 1 : 0)) * (PSV + 1));
    end
    check(dma_req, 32'h1, "dma request");
    wr(`ATB_OFS_CTRL1, 32'h1);
    wr(`ATB_OFS_PSC, 32'h3);
    gap((RPV + 1) * (RLD + 1) * 4);
    wr(`ATB_OFS_CTRL1, 32'h3);
    repeat (4) @(negedge ref_clk);
    hits = 0;
    repeat (200) @(negedge ref_clk) if (update_evt === 1'b1) hits = hits + 1;
    check(hits, 32'h0, "disabled updates");
    wr(`ATB_OFS_CTRL1, 32'h0);
    wr(`ATB_OFS_STS, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`ATB_OFS_IEN, 32'h4 << i);
      wr(`ATB_OFS_CNT, 32'h1230 + i);
      far.pulse(2'h0, i[1:0], 4'h1);
      rd(`ATB_OFS_STS, 32'h3F, 32'h4 << i, "capture flag");
      check(irq, 32'h1, "capture irq");
      rd(`ATB_OFS_CCV0 + {i[3:0], 2'h0}, 32'hFFFF, 32'h1230 + i, "capture value");
      wr(`ATB_OFS_STS, 32'h0);
      check(irq, 32'h0, "irq cleared");
    end
    wr(`ATB_OFS_RELOAD, 32'hFFFF);
    wr(`ATB_OFS_PSC, 32'h0);
    wr(`ATB_OFS_EVGEN, 32'h1);
    wr(`ATB_OFS_SMC, ext_tab[0][31:16]);
    wr(`ATB_OFS_CTRL1, 32'h1);
    cnt_exp = 16'h0000;
    for (i = 0; i < 5; i = i + 1) begin
      wr(`ATB_OFS_SMC, ext_tab[i][31:16]);
      far.pulse(ext_tab[i][9:8], ext_tab[i][5:4], ext_tab[i][3:0]);
      cnt_exp = cnt_exp + ext_tab[i][3:0] * (ext_tab[i][31:16] == 16'h0011 ? 2 : 1);
      repeat (4) @(posedge ref_clk);
      rd(`ATB_OFS_CNT, 32'hFFFF, cnt_exp, "external count");
    end
    rd(`ATB_OFS_STS, 32'h2, 32'h2, "trigger flag");
    wr(`ATB_OFS_CAPCFG, 32'h30000);
    far.pulse(2'h0, 2'h1, 4'h1);
    rd(`ATB_OFS_CCV0, 32'hFFFF, cnt_exp, "pwm capture");
    check(trg, cnt_exp, "trigger pulses");
    wr(`ATB_OFS_REP, 32'h1FF);
    rd(`ATB_OFS_REP, 32'hFFFF, 32'hFF, "repetition width");
    complete_run;
  end
endmodule // tb_atb_timer

// >>> verilog/atb_timer.v
// Purpose: 16-bit timebase with prescaler, repetition counter, clock source
//          selection, slave actions and four input capture channels
// Assumes: all inputs synchronous to ref_clk; Avalon-MM slave, one wait cycle
// Notes:   output compare, break, dead-time and DMA bursts are not present
`timescale 1ns/10ps
`include "atb_timer_consts.vh"

// Behaviour
// - sixteen-bit counter counting up, down or center-aligned.
// - direction select field in control register one picks the counting mode.
// - up mode counts from 0, wraps to 0 at reload, flags overflow.
// - down mode counts from reload to 0, reloads, flags wrap.
// - center mode rises to reload and falls; overflow at reload-1, underflow at 1.
// - update event copies pending repetition, reload and prescaler into shadows.
// - update-disable bit suppresses update events from counter wraps.
// - each wrap decrements repetition counter; update only when it is 0.
// - repetition count register is eight bits wide.
// - prescaler divides counter clock by 1 to 65536 and drives the counter.
// - prescaler value is buffered; rewrites take effect at next update.
// - with slave control off, the prescaler runs from the internal clock.
// - external mode one clocks from any filtered channel, or channel 1 both edges.
// - external mode two uses trigger input after polarity, divider and filter.
// - internal trigger comes unfiltered; it may reset, start, gate or clock.
// - PWM input measurement takes its source from input 1 or 2 only.
// - four independent capture channels, each with its own value register.
// - capture path is filter, edge detect and event prescaler before latching.
// - a selected edge latches the counter into the channel value register.
// - capture sets the channel flag; interrupt when its enable is 1.
// - interrupt requests for update, trigger and capture events; DMA request for update only.
module atb_timer (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [3:0] ch_in,
  input wire external_trigger_input,
  input wire [3:0] itr_in,
  output wire [15:0] counter_value,
  output reg update_evt,
  output reg trigger_evt,
  output wire irq,
  output wire dma_req
);

  // ==========================================================
  // helpers
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wdata;
    input [3:0] be;
    begin
      merge16[7:0] = be[0] ? wdata[7:0] : old[7:0];
      merge16[15:8] = be[1] ? wdata[15:8] : old[15:8];
    end
  endfunction

  function sel4;
    input [3:0] v;
    input [1:0] s;
    begin
      sel4 = v[s];
    end
  endfunction

  function edge_hit;
    input r;
    input f;
    input [1:0] mode;
    begin
      case (mode)
        2'h0: edge_hit = r;
        2'h1: edge_hit = f;
        default: edge_hit = r | f;
      endcase
    end
  endfunction

  // ==========================================================
  // registers
  reg [15:0] ctrl1_ff;
  reg [16:0] smc_ff;
  reg [5:0] sts_ff;
  reg [8:0] ien_ff;
  reg [17:0] capcfg_ff;
  reg [15:0] cnt_ff;
  reg [15:0] psc_ff;
  reg [15:0] reload_ff;
  reg [7:0] rep_ff;
  reg [15:0] psc_act_ff;
  reg [15:0] reload_act_ff;
  reg [7:0] rep_act_ff;
  reg [7:0] rep_cnt_ff;
  reg [15:0] psc_cnt_ff;
  reg down_ff;
  reg [15:0] ccv_ff [0:3];
  reg [2:0] evc_ff [0:3];
  reg ack_ff;
  reg [2:0] etr_div_ff;
  reg etr_prev_ff;
  reg [3:0] itr_prev_ff;
  reg [4:0] filt_ff;
  reg [4:0] filt_prev_ff;
  reg [3:0] fcnt_ff [0:4];
  integer i;
  integer j;
  integer k;
  integer m;

  wire [1:0] dir_sel = ctrl1_ff[`ATB_CTRL_DIR_LO+1:`ATB_CTRL_DIR_LO];
  wire [1:0] clk_mode = smc_ff[`ATB_SMC_MODE_LO+1:`ATB_SMC_MODE_LO];
  wire [2:0] in_sel = smc_ff[`ATB_SMC_ISEL_LO+2:`ATB_SMC_ISEL_LO];
  wire [1:0] etr_div = smc_ff[`ATB_SMC_EDIV_LO+1:`ATB_SMC_EDIV_LO];
  wire [3:0] flt_len = smc_ff[`ATB_SMC_FLT_LO+3:`ATB_SMC_FLT_LO];
  wire [1:0] itr_sel = smc_ff[`ATB_SMC_TSEL_LO+1:`ATB_SMC_TSEL_LO];
  wire [1:0] slv_act = smc_ff[`ATB_SMC_ACT_LO+1:`ATB_SMC_ACT_LO];
  wire pwm_mode = capcfg_ff[`ATB_CAP_PWM];

  // ==========================================================
  // bus handshake: one wait cycle, answer on the second cycle
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ack_ff;
  assign avs_waitrequest = req & ~ack_ff;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else if (clk_en) begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // ==========================================================
  // external trigger: polarity, then divide by 1/2/4/8
  wire etr_pol = external_trigger_input ^ smc_ff[`ATB_SMC_EPOL];
  reg etr_divided;

  always @* begin
    case (etr_div)
      2'h0: etr_divided = etr_pol;
      2'h1: etr_divided = etr_div_ff[0];
      2'h2: etr_divided = etr_div_ff[1];
      default: etr_divided = etr_div_ff[2];
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      etr_div_ff <= 3'h0;
      etr_prev_ff <= 1'b0;
      itr_prev_ff <= 4'h0;
    end else if (clk_en) begin
      etr_prev_ff <= etr_pol;
      itr_prev_ff <= itr_in;
      if (etr_pol & ~etr_prev_ff)
        etr_div_ff <= etr_div_ff + 3'h1;
    end
  end

  // ==========================================================
  // input filters: a level must hold flt_len+1 samples before it passes
  wire [4:0] raw_in = {etr_divided, ch_in};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_ff <= 5'h00;
      filt_prev_ff <= 5'h00;
      for (i = 0; i < 5; i = i + 1)
        fcnt_ff[i] <= 4'h0;
    end else if (clk_en) begin
      filt_prev_ff <= filt_ff;
      for (i = 0; i < 5; i = i + 1) begin
        if (raw_in[i] == filt_ff[i]) begin
          fcnt_ff[i] <= 4'h0;
        end else if (fcnt_ff[i] >= flt_len) begin
          filt_ff[i] <= raw_in[i];
          fcnt_ff[i] <= 4'h0;
        end else begin
          fcnt_ff[i] <= fcnt_ff[i] + 4'h1;
        end
      end
    end
  end

  wire [4:0] rise = filt_ff & ~filt_prev_ff;
  wire [4:0] fall = ~filt_ff & filt_prev_ff;
  wire [3:0] itr_rise = itr_in & ~itr_prev_ff;

  // ==========================================================
  // trigger selection for the slave mode controller
  reg trig_edge;
  reg trig_level;

  always @* begin
    trig_edge = 1'b0;
    trig_level = 1'b0;
    case (clk_mode)
      `ATB_CLK_EXT1: begin
        if (in_sel == `ATB_ISEL_BOTH) begin
          trig_edge = rise[0] | fall[0];
          trig_level = filt_ff[0];
        end else if (smc_ff[`ATB_SMC_IPOL]) begin
          trig_edge = sel4(fall[3:0], in_sel[1:0]);
          trig_level = ~sel4(filt_ff[3:0], in_sel[1:0]);
        end else begin
          trig_edge = sel4(rise[3:0], in_sel[1:0]);
          trig_level = sel4(filt_ff[3:0], in_sel[1:0]);
        end
      end
      `ATB_CLK_EXT2: begin
        trig_edge = rise[4];
        trig_level = filt_ff[4];
      end
      `ATB_CLK_ITR: begin
        trig_edge = sel4(itr_rise, itr_sel);
        trig_level = sel4(itr_in, itr_sel);
      end
      default: begin
        trig_edge = 1'b0;
        trig_level = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // capture edge detection; PWM input pairs channels 1 and 2
  wire pwm_r = capcfg_ff[`ATB_CAP_PWM_SRC] ? rise[1] : rise[0];
  wire pwm_f = capcfg_ff[`ATB_CAP_PWM_SRC] ? fall[1] : fall[0];
  reg [3:0] cap_edge;

  always @* begin
    for (j = 0; j < 4; j = j + 1)
      cap_edge[j] = edge_hit(rise[j], fall[j], capcfg_ff[4*j +: 2]);
    if (pwm_mode) begin
      cap_edge[0] = edge_hit(pwm_r, pwm_f, capcfg_ff[1:0]);
      cap_edge[1] = edge_hit(pwm_f, pwm_r, capcfg_ff[1:0]); // opposite edge
    end
  end

  // event prescaler: capture on every 1st, 2nd, 4th or 8th selected edge
  reg [3:0] cap_fire;

  always @* begin
    for (k = 0; k < 4; k = k + 1)
      cap_fire[k] = cap_edge[k] &
        (evc_ff[k] == ((3'h1 << capcfg_ff[4*k+2 +: 2]) - 3'h1));
  end

  // ==========================================================
  // clocking of the prescaler
  wire slave_on = (clk_mode != `ATB_CLK_INT);
  reg src_pulse;

  always @* begin
    if (!slave_on)
      src_pulse = 1'b1;
    else if (slv_act == `ATB_ACT_CLOCK)
      src_pulse = trig_edge;
    else if (slv_act == `ATB_ACT_GATE)
      src_pulse = trig_level;
    else
      src_pulse = 1'b1;
  end

  wire cen = ctrl1_ff[`ATB_CTRL_CEN];
  wire psc_tick = cen & src_pulse & (psc_cnt_ff == psc_act_ff);
  wire slave_reset = (slave_on & (slv_act == `ATB_ACT_RESET) & trig_edge) |
                     (pwm_mode & cap_edge[0]);
  wire slave_start = slave_on & (slv_act == `ATB_ACT_START) & trig_edge;

  // ==========================================================
  // counter next value and wrap detection
  reg [15:0] nxt_cnt;
  reg nxt_down;
  reg wrap;

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_down = down_ff;
    wrap = 1'b0;
    case (dir_sel)
      `ATB_DIR_UP: begin
        nxt_down = 1'b0;
        if (cnt_ff == reload_act_ff) begin
          nxt_cnt = 16'h0000;
          wrap = 1'b1;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      `ATB_DIR_DOWN: begin
        nxt_down = 1'b1;
        if (cnt_ff == 16'h0000) begin
          nxt_cnt = reload_act_ff;
          wrap = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      default: begin
        if (reload_act_ff == 16'h0000) begin
          nxt_cnt = 16'h0000;
        end else if (!down_ff) begin
          wrap = (cnt_ff == reload_act_ff - 16'h0001);
          if (cnt_ff >= reload_act_ff) begin
            nxt_down = 1'b1;
            nxt_cnt = cnt_ff - 16'h0001;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end else begin
          wrap = (cnt_ff == 16'h0001);
          if (cnt_ff == 16'h0000) begin
            nxt_down = 1'b0;
            nxt_cnt = 16'h0001;
          end else begin
            nxt_cnt = cnt_ff - 16'h0001;
          end
        end
      end
    endcase
  end

  // ==========================================================
  // update event sources
  wire sel_hit = (avs_address == `ATB_OFS_EVGEN) & wr_go;
  wire sw_update = sel_hit & avs_byteenable[0] & avs_writedata[`ATB_EVG_UPD];
  wire tick_wrap = psc_tick & wrap;
  wire wrap_update = tick_wrap & (rep_cnt_ff == 8'h00) & ~ctrl1_ff[`ATB_CTRL_UD];
  wire init_update = sw_update | slave_reset;
  wire do_update = wrap_update | init_update;
  wire [15:0] init_cnt = (dir_sel == `ATB_DIR_DOWN) ? reload_ff : 16'h0000;

  // ==========================================================
  // timebase, shadows and repetition counter
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= `ATB_RST_ZERO16;
      down_ff <= 1'b0;
      psc_cnt_ff <= `ATB_RST_ZERO16;
      psc_act_ff <= `ATB_RST_ZERO16;
      reload_act_ff <= `ATB_RST_RELOAD;
      rep_act_ff <= `ATB_RST_REP;
      rep_cnt_ff <= `ATB_RST_REP;
    end else if (clk_en) begin
      // prescaler divides by psc+1; restarted by any update
      if (init_update | psc_tick)
        psc_cnt_ff <= 16'h0000;
      else if (cen & src_pulse)
        psc_cnt_ff <= psc_cnt_ff + 16'h0001;
      // counter: software write wins over hardware motion
      if (wr_go & (avs_address == `ATB_OFS_CNT)) begin
        cnt_ff <= merge16(cnt_ff, avs_writedata, avs_byteenable);
      end else if (init_update) begin
        cnt_ff <= init_cnt;
        down_ff <= 1'b0;
      end else if (psc_tick) begin
        cnt_ff <= nxt_cnt;
        down_ff <= nxt_down;
      end
      // shadows only move on an update, so mid-period rewrites are harmless
      if (do_update) begin
        psc_act_ff <= psc_ff;
        reload_act_ff <= reload_ff;
        rep_act_ff <= rep_ff;
        rep_cnt_ff <= rep_ff;
      end else if (tick_wrap) begin
        if (rep_cnt_ff == 8'h00)
          rep_cnt_ff <= rep_act_ff; // update held off by the disable bit
        else
          rep_cnt_ff <= rep_cnt_ff - 8'h01;
      end
    end
  end

  // ==========================================================
  // capture channels
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (m = 0; m < 4; m = m + 1) begin
        ccv_ff[m] <= `ATB_RST_ZERO16;
        evc_ff[m] <= 3'h0;
      end
    end else if (clk_en) begin
      for (m = 0; m < 4; m = m + 1) begin
        if (cap_fire[m]) begin
          ccv_ff[m] <= cnt_ff;
          evc_ff[m] <= 3'h0;
        end else if (cap_edge[m]) begin
          evc_ff[m] <= evc_ff[m] + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // software registers and sticky status
  wire [5:0] sts_set = {cap_fire, (slave_on & trig_edge), do_update};

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1_ff <= `ATB_RST_ZERO16;
      smc_ff <= 17'h00000;
      sts_ff <= 6'h00;
      ien_ff <= 9'h000;
      capcfg_ff <= 18'h00000;
      psc_ff <= `ATB_RST_ZERO16;
      reload_ff <= `ATB_RST_RELOAD;
      rep_ff <= `ATB_RST_REP;
      update_evt <= 1'b0;
      trigger_evt <= 1'b0;
    end else if (clk_en) begin
      update_evt <= do_update;
      trigger_evt <= slave_on & trig_edge;
      // status bits clear on a written 0; a same-cycle event wins
      if (wr_go & (avs_address == `ATB_OFS_STS) & avs_byteenable[0])
        sts_ff <= (sts_ff & avs_writedata[5:0]) | sts_set;
      else
        sts_ff <= sts_ff | sts_set;
      if (wr_go) begin
        case (avs_address)
          `ATB_OFS_CTRL1: ctrl1_ff <= merge16(ctrl1_ff, avs_writedata, avs_byteenable);
          `ATB_OFS_SMC: begin
            smc_ff[15:0] <= merge16(smc_ff[15:0], avs_writedata, avs_byteenable);
            if (avs_byteenable[2])
              smc_ff[16] <= avs_writedata[16];
          end
          `ATB_OFS_IEN: begin
            if (avs_byteenable[0])
              ien_ff[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1])
              ien_ff[8] <= avs_writedata[8];
          end
          `ATB_OFS_CAPCFG: begin
            capcfg_ff[15:0] <= merge16(capcfg_ff[15:0], avs_writedata, avs_byteenable);
            if (avs_byteenable[2])
              capcfg_ff[17:16] <= avs_writedata[17:16];
          end
          `ATB_OFS_PSC: psc_ff <= merge16(psc_ff, avs_writedata, avs_byteenable);
          `ATB_OFS_RELOAD: reload_ff <= merge16(reload_ff, avs_writedata, avs_byteenable);
          `ATB_OFS_REP: begin
            if (avs_byteenable[0])
              rep_ff <= avs_writedata[7:0];
          end
          default: begin
          end
        endcase
      end
      // a start trigger sets the enable; same-cycle software write loses
      if (slave_start)
        ctrl1_ff[`ATB_CTRL_CEN] <= 1'b1;
    end
  end

  // ==========================================================
  // read data, captured during the wait cycle
  reg [31:0] rd_mux;

  always @* begin
    case (avs_address)
      `ATB_OFS_CTRL1: rd_mux = {16'h0000, ctrl1_ff};
      `ATB_OFS_SMC: rd_mux = {15'h0000, smc_ff};
      `ATB_OFS_STS: rd_mux = {26'h0000000, sts_ff};
      `ATB_OFS_IEN: rd_mux = {23'h000000, ien_ff};
      `ATB_OFS_CAPCFG: rd_mux = {14'h0000, capcfg_ff};
      `ATB_OFS_CNT: rd_mux = {16'h0000, cnt_ff};
      `ATB_OFS_PSC: rd_mux = {16'h0000, psc_ff};
      `ATB_OFS_RELOAD: rd_mux = {16'h0000, reload_ff};
      `ATB_OFS_REP: rd_mux = {24'h000000, rep_ff};
      6'h24: rd_mux = {16'h0000, ccv_ff[0]};
      6'h28: rd_mux = {16'h0000, ccv_ff[1]};
      6'h2C: rd_mux = {16'h0000, ccv_ff[2]};
      `ATB_OFS_CCV3: rd_mux = {16'h0000, ccv_ff[3]};
      default: rd_mux = 32'h00000000; // unmapped and write-only read as zero
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
      if (avs_read & ~ack_ff)
        avs_readdata <= rd_mux;
    end
  end

  // ==========================================================
  // outputs
  assign counter_value = cnt_ff;
  assign irq = |(sts_ff & ien_ff[5:0]);
  assign dma_req = sts_ff[`ATB_STS_UPD] & ien_ff[`ATB_IEN_UDMA];

endmodule // atb_timer

// >>> verilog/atb_timer_consts.vh
// Purpose: constants for the advanced timebase / capture timer core
// Assumes: Avalon-MM word offsets are byte addresses, 32-bit data bus
// Notes:   register fields sit in the low bits; SMC and CAPCFG reach bits 16 and 17
`ifndef ATB_TIMER_CONSTS_VH
`define ATB_TIMER_CONSTS_VH

// ==========================================================
// register byte offsets
`define ATB_OFS_CTRL1    6'h00
`define ATB_OFS_SMC      6'h04
`define ATB_OFS_STS      6'h08
`define ATB_OFS_IEN      6'h0C
`define ATB_OFS_CAPCFG   6'h10
`define ATB_OFS_CNT      6'h14
`define ATB_OFS_PSC      6'h18
`define ATB_OFS_RELOAD   6'h1C
`define ATB_OFS_REP      6'h20
`define ATB_OFS_CCV0     6'h24
`define ATB_OFS_CCV3     6'h30
`define ATB_OFS_EVGEN    6'h34

// ==========================================================
// timer_control_one fields
`define ATB_CTRL_CEN     0
`define ATB_CTRL_UD      1
`define ATB_CTRL_DIR_LO  2
`define ATB_DIR_UP       2'h0
`define ATB_DIR_DOWN     2'h1
`define ATB_DIR_CENTER   2'h2

// ==========================================================
// slave mode / clock source fields
`define ATB_SMC_MODE_LO  0
`define ATB_SMC_ISEL_LO  2
`define ATB_SMC_IPOL     5
`define ATB_SMC_EDIV_LO  6
`define ATB_SMC_EPOL     8
`define ATB_SMC_FLT_LO   9
`define ATB_SMC_TSEL_LO  13
`define ATB_SMC_ACT_LO   15
`define ATB_CLK_INT      2'h0
`define ATB_CLK_EXT1     2'h1
`define ATB_CLK_EXT2     2'h2
`define ATB_CLK_ITR      2'h3
`define ATB_ACT_CLOCK    2'h0
`define ATB_ACT_RESET    2'h1
`define ATB_ACT_GATE     2'h2
`define ATB_ACT_START    2'h3
`define ATB_ISEL_BOTH    3'h4

// ==========================================================
// status / enable fields, capture config
`define ATB_STS_UPD      0
`define ATB_STS_TRG      1
`define ATB_STS_CC_LO    2
`define ATB_IEN_UDMA     8
`define ATB_CAP_PWM      16
`define ATB_CAP_PWM_SRC  17
`define ATB_EVG_UPD      0

// ==========================================================
// reset values
`define ATB_RST_RELOAD   16'hFFFF
`define ATB_RST_ZERO16   16'h0000
`define ATB_RST_REP      8'h00

`endif
